// ### amsq_host_model.sv
`timescale 1ns/1ns
module amsq_host_model (
  // Serial pins toward the device
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_din,
  // Device serial output and its enable
  input wire logic i_dout,
  input wire logic i_dout_oe
);
  logic miso;
  logic miso_last = 1'b0;
  // A released line shows the inverse of its last level, so a float never reads as data
  assign miso = i_dout_oe ? i_dout : ~miso_last;
  always @(negedge o_sclk) if (!o_cs_n) miso_last <= miso;
  // Serial clock stands low between frames
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_din = 1'b0;
  end
  // One frame of 16 bits, MSB first; the 1 ns offset keeps pin edges off the system clock
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    rx = 16'h0000;
    #1 o_cs_n = 1'b0;
    #40;
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b1;
      o_din = tx[i];
      #40 o_sclk = 1'b0;
      rx = {rx[14:0], miso};
      #40;
    end
    o_cs_n = 1'b1;
    #80;
  endtask : xfer
endmodule : amsq_host_model

// ### amsq_pkg.sv
package amsq_pkg;
  typedef enum logic [1:0] {
    MD_RUN = 2'b00, MD_STANDBY = 2'b01, MD_WAKE = 2'b10, MD_DETECT = 2'b11
  } amsq_mode_t;
  typedef enum logic [1:0] {
    GC_START = 2'b00, GC_DELAY = 2'b01, GC_CONV = 2'b10, GC_OFF = 2'b11
  } amsq_gc_t;
  typedef struct packed {
    logic chop_enable;
    logic [3:0] chop_settle_delay;
    logic [2:0] osr_select;
  } amsq_chop_cfg_t;
  typedef struct packed {
    logic detect_enable;
    logic detect_all_channels;
    logic [2:0] detect_sample_length;
    logic [2:0] detect_hit_count;
    logic [15:0] detect_threshold_high;
    logic [7:0] detect_threshold_low;
  } amsq_cd_cfg_t;
  typedef logic [5:0][23:0] amsq_cd_samples_t;
endpackage : amsq_pkg

// ### amsq_regs.svh
// What this block does
// - Chop flips polarity, averages last two conversions
// - Filter reset on each polarity swap
// - Settle delay 2 to 65536 periods selectable
// - Chop period is delay plus 3xOSR
// - Sync fall or OSR change restarts chop
// - First chop result adds 44 extra periods
// - Chop mode disables phase calibration
// - Three power modes from 2-bit field
// - Standby command disables channels, keeps settings
// - Wake command, sampling after 8 periods
// - Short sync pulse enters detect from standby
// - Detect samples on internal oscillator, hidden
// - Enough hits: data-ready fall, back to standby
// - 24-bit threshold; detect enable bit
// - Length field: 128 to 3584 samples
// - Hit count field rejects isolated exceedances
// - All-channels bit selects all or any
// - Only enabled channels join detection
// - Serial mode 1: launch rise, sample fall
// - Chip select high floats output, resets port
// - Long sync low resets until released
// - Data-ready is active low
`ifndef AMSQ_REGS_SVH
`define AMSQ_REGS_SVH
`define AMSQ_CMD_STANDBY 16'h0022
`define AMSQ_CMD_EXIT_STANDBY_COMMAND 16'h0033
`define AMSQ_CMD_BITS 5'h10
`define AMSQ_FIRST_EXTRA_MOD 17'h0002c
`define AMSQ_WAKE_SETTLE_MOD 17'h00008
`define AMSQ_OSR_BASE 17'h00080
`define AMSQ_DLY_BASE 17'h00002
`define AMSQ_CLK_PERIOD_NS 4
`define AMSQ_RESET_PULSE_NS 1000
`define AMSQ_RESET_PULSE_CYC ((`AMSQ_RESET_PULSE_NS + `AMSQ_CLK_PERIOD_NS - 1) / `AMSQ_CLK_PERIOD_NS)
`define AMSQ_CD_PERIOD_NS 370370
`define AMSQ_CD_TICK_CYC (`AMSQ_CD_PERIOD_NS / `AMSQ_CLK_PERIOD_NS)
`define AMSQ_DATA_READY_N_LOW_CYC 4'h8
`define AMSQ_PIN_IDLE 5'h0a
`endif

// ### amsq_top.sv
`timescale 1ns/1ns
`include "amsq_regs.svh"
module amsq_top import amsq_pkg::*; #(
  parameter int unsigned CD_TICK_CYC = `AMSQ_CD_TICK_CYC
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Serial port pins
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_din,
  output logic o_dout,
  output logic o_dout_oe,
  // Control pins
  input wire logic i_sync_rst_n,
  input wire logic i_converter_clock_in,
  output logic o_data_ready_n,
  // Configuration
  input amsq_chop_cfg_t i_chop_cfg,
  input wire logic [1:0] i_power_mode_select,
  input amsq_cd_cfg_t i_cd_cfg,
  input wire logic [5:0] i_channel_enable_bits,
  // Converter datapath
  input wire logic signed [23:0] i_raw_result,
  input amsq_cd_samples_t i_cd_samples,
  output logic signed [23:0] o_chop_result,
  // Converter control and status
  output logic o_input_swap,
  output logic o_filter_reset,
  output logic o_modulator_run,
  output logic [5:0] o_channel_run,
  output logic o_standby,
  output logic o_osc_enable,
  output logic o_phase_cal_off,
  output logic [1:0] o_power_mode,
  output logic o_device_reset
);
  localparam int unsigned RST_CYC = `AMSQ_RESET_PULSE_CYC;

  logic [4:0] sync1_reg, sync2_reg, prev_reg;
  logic sclk_rise, sclk_fall, cs_hi, sync_fall, sync_rise, mod_tick;
  logic [15:0] low_cnt_reg;
  logic pin_reset_reg, rst_all;
  logic [4:0] bit_cnt_reg;
  logic [15:0] shift_in_reg, shift_out_reg;
  logic cmd_stb_reg;
  logic [15:0] cmd_reg;
  amsq_mode_t mode_reg;
  amsq_gc_t gc_reg;
  logic [16:0] tick_cnt_reg, dly_len, conv_len;
  logic [2:0] osr_reg;
  logic have_prev_reg, restart, gc_done;
  logic signed [23:0] prev_reg_res;
  logic [16:0] osc_cnt_reg;
  logic [11:0] samp_cnt_reg, samp_len;
  logic [5:0][3:0] hits_reg;
  logic [5:0] over, met;
  logic [3:0] need;
  logic [23:0] thr;
  logic detected, cd_tick, cd_entry;
  logic [3:0] data_ready_n_cnt_reg;
  logic data_ready_n_start;

  // Two flops on every pin before use; edges compare stage two with stage three
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sync1_reg <= `AMSQ_PIN_IDLE;
      sync2_reg <= `AMSQ_PIN_IDLE;
      prev_reg <= `AMSQ_PIN_IDLE;
    end else begin
      sync1_reg <= {i_converter_clock_in, i_sync_rst_n, i_din, i_cs_n, i_sclk};
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end

  assign sclk_rise = sync2_reg[0] & ~prev_reg[0];
  assign sclk_fall = ~sync2_reg[0] & prev_reg[0];
  assign cs_hi = sync2_reg[1];
  assign sync_fall = ~sync2_reg[3] & prev_reg[3];
  assign sync_rise = sync2_reg[3] & ~prev_reg[3];
  assign mod_tick = sync2_reg[4] & ~prev_reg[4]; // One modulator period per rising clock edge

  // Sync pin low time; a long low holds the device in reset until release
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      low_cnt_reg <= 16'h0000;
      pin_reset_reg <= 1'b0;
    end else if (sync2_reg[3]) begin
      low_cnt_reg <= 16'h0000;
      pin_reset_reg <= 1'b0;
    end else begin
      if (low_cnt_reg < 16'(RST_CYC)) begin
        low_cnt_reg <= low_cnt_reg + 16'h0001;
      end
      if (low_cnt_reg >= 16'(RST_CYC)) begin
        pin_reset_reg <= 1'b1;
      end
    end
  end
  assign rst_all = i_rst | pin_reset_reg;

  // Serial port: mode 1, launch on rise, sample on fall; only the first word is a command
  always_ff @(posedge i_clk_sys) begin
    if (rst_all || cs_hi) begin
      bit_cnt_reg <= 5'h00;
      shift_in_reg <= 16'h0000;
      shift_out_reg <= {o_standby, o_osc_enable, i_chop_cfg.chop_enable, o_power_mode, 11'h000};
      o_dout <= 1'b0;
      o_dout_oe <= 1'b0;
      cmd_stb_reg <= 1'b0;
      cmd_reg <= 16'h0000;
    end else begin
      o_dout_oe <= 1'b1;
      cmd_stb_reg <= 1'b0;
      if (sclk_rise) begin
        o_dout <= shift_out_reg[15];
        shift_out_reg <= {shift_out_reg[14:0], 1'b0};
      end
      if (sclk_fall && bit_cnt_reg < `AMSQ_CMD_BITS) begin
        shift_in_reg <= {shift_in_reg[14:0], sync2_reg[2]};
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
        if (bit_cnt_reg == `AMSQ_CMD_BITS - 5'h01) begin
          cmd_stb_reg <= 1'b1;
          cmd_reg <= {shift_in_reg[14:0], sync2_reg[2]};
        end
      end
    end
  end

  // Detect tick from the internal oscillator stand-in
  assign cd_tick = (mode_reg == MD_DETECT) && (osc_cnt_reg == 17'(CD_TICK_CYC - 1));
  assign cd_entry = (mode_reg == MD_STANDBY) && sync_rise && i_cd_cfg.detect_enable
                    && (low_cnt_reg < 16'(RST_CYC)) && !pin_reset_reg;

  // Power state: run, standby, wake settling, current detect
  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      mode_reg <= MD_RUN;
      osc_cnt_reg <= 17'h00000;
    end else begin
      osc_cnt_reg <= (mode_reg != MD_DETECT || cd_tick) ? 17'h00000 : osc_cnt_reg + 17'h00001;
      case (mode_reg)
        MD_RUN: begin
          if (cmd_stb_reg && cmd_reg == `AMSQ_CMD_STANDBY) mode_reg <= MD_STANDBY;
        end
        MD_STANDBY: begin
          if (cmd_stb_reg && cmd_reg == `AMSQ_CMD_EXIT_STANDBY_COMMAND) mode_reg <= MD_WAKE;
          else if (cd_entry) mode_reg <= MD_DETECT;
        end
        MD_WAKE: begin
          if (cmd_stb_reg && cmd_reg == `AMSQ_CMD_STANDBY) mode_reg <= MD_STANDBY;
          else if (mod_tick && tick_cnt_reg == `AMSQ_WAKE_SETTLE_MOD - 17'h00001) begin
            mode_reg <= MD_RUN;
          end
        end
        MD_DETECT: begin
          if (cd_tick && detected) mode_reg <= MD_STANDBY;
          else if (cmd_stb_reg && cmd_reg == `AMSQ_CMD_STANDBY) mode_reg <= MD_STANDBY;
        end
        default: mode_reg <= MD_RUN;
      endcase
    end
  end

  // Chop sequence lengths in modulator periods
  assign dly_len = `AMSQ_DLY_BASE << i_chop_cfg.chop_settle_delay;
  assign conv_len = 17'((`AMSQ_OSR_BASE << osr_reg) * 3);
  assign restart = (mode_reg == MD_RUN) && (sync_fall || osr_reg != i_chop_cfg.osr_select);
  assign gc_done = (gc_reg == GC_CONV) && mod_tick && tick_cnt_reg == conv_len - 17'h00001;

  // Chop sequencer: 44-period lead-in, then delay and triple conversion per swap
  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      gc_reg <= GC_OFF;
      tick_cnt_reg <= 17'h00000;
      osr_reg <= 3'h0;
      o_input_swap <= 1'b0;
      o_filter_reset <= pin_reset_reg;
      have_prev_reg <= 1'b0;
      prev_reg_res <= 24'sh000000;
      o_chop_result <= 24'sh000000;
    end else begin
      osr_reg <= i_chop_cfg.osr_select;
      o_filter_reset <= 1'b0;
      if (mode_reg == MD_WAKE) begin
        gc_reg <= GC_OFF;
        if (mod_tick) tick_cnt_reg <= tick_cnt_reg + 17'h00001;
      end else if (mode_reg != MD_RUN || !i_chop_cfg.chop_enable) begin
        gc_reg <= GC_OFF;
        tick_cnt_reg <= 17'h00000;
      end else if (restart || gc_reg == GC_OFF) begin
        gc_reg <= GC_START;
        tick_cnt_reg <= 17'h00000;
        o_input_swap <= 1'b0;
        o_filter_reset <= 1'b1;
        have_prev_reg <= 1'b0;
      end else if (mod_tick) begin
        tick_cnt_reg <= tick_cnt_reg + 17'h00001;
        case (gc_reg)
          GC_START: begin
            if (tick_cnt_reg == `AMSQ_FIRST_EXTRA_MOD - 17'h00001) begin
              gc_reg <= GC_DELAY;
              tick_cnt_reg <= 17'h00000;
            end
          end
          GC_DELAY: begin
            if (tick_cnt_reg == dly_len - 17'h00001) begin
              gc_reg <= GC_CONV;
              tick_cnt_reg <= 17'h00000;
            end
          end
          GC_CONV: begin
            if (gc_done) begin
              gc_reg <= GC_DELAY;
              tick_cnt_reg <= 17'h00000;
              o_input_swap <= ~o_input_swap;
              o_filter_reset <= 1'b1;
              prev_reg_res <= i_raw_result;
              have_prev_reg <= 1'b1;
              // Sliding pair average; the shift keeps the sign
              o_chop_result <= 24'((25'(prev_reg_res) + 25'(i_raw_result)) >>> 1);
            end
          end
          default: gc_reg <= GC_START;
        endcase
      end
    end
  end

  // Detect thresholds and per-channel comparison of magnitudes
  assign thr = {i_cd_cfg.detect_threshold_high, i_cd_cfg.detect_threshold_low};
  assign need = {1'b0, i_cd_cfg.detect_hit_count} + 4'h1;
  always_comb begin
    samp_len = 12'h080;
    case (i_cd_cfg.detect_sample_length)
      3'h0: samp_len = 12'h080;
      3'h1: samp_len = 12'h100;
      3'h2: samp_len = 12'h200;
      3'h3: samp_len = 12'h300;
      3'h4: samp_len = 12'h500;
      3'h5: samp_len = 12'h700;
      3'h6: samp_len = 12'ha00;
      default: samp_len = 12'he00;
    endcase
  end
  for (genvar c = 0; c < 6; c++) begin : g_ch
    logic [23:0] mag;
    assign mag = i_cd_samples[c][23] ? 24'(-i_cd_samples[c]) : i_cd_samples[c];
    assign over[c] = i_channel_enable_bits[c] && (mag > thr);
    assign met[c] = (hits_reg[c] + {3'h0, over[c]}) >= need;
  end
  assign detected = i_cd_cfg.detect_all_channels
                    ? ((&(met | ~i_channel_enable_bits)) && (|i_channel_enable_bits))
                    : (|(met & i_channel_enable_bits));

  // Detect run counters; results never leave the block
  always_ff @(posedge i_clk_sys) begin
    if (rst_all || cd_entry) begin
      samp_cnt_reg <= 12'h000;
      hits_reg <= '0;
    end else if (cd_tick) begin
      if (detected || samp_cnt_reg == samp_len - 12'h001) begin
        samp_cnt_reg <= 12'h000;
        hits_reg <= '0;
      end else begin
        samp_cnt_reg <= samp_cnt_reg + 12'h001;
        for (int c = 0; c < 6; c++) begin
          // Saturate so a channel that already met its count cannot wrap back
          if (over[c] && hits_reg[c] < 4'h8) hits_reg[c] <= hits_reg[c] + 4'h1;
        end
      end
    end
  end

  // Data-ready low pulse for each chop result or detection
  assign data_ready_n_start = (gc_done && have_prev_reg && mode_reg == MD_RUN && !restart)
                      || (cd_tick && detected);
  always_ff @(posedge i_clk_sys) begin
    if (rst_all) begin
      data_ready_n_cnt_reg <= 4'h0;
      o_data_ready_n <= 1'b1;
    end else if (data_ready_n_start) begin
      data_ready_n_cnt_reg <= `AMSQ_DATA_READY_N_LOW_CYC - 4'h1;
      o_data_ready_n <= 1'b0;
    end else if (data_ready_n_cnt_reg != 4'h0) begin
      data_ready_n_cnt_reg <= data_ready_n_cnt_reg - 4'h1;
    end else begin
      o_data_ready_n <= 1'b1;
    end
  end

  // Status and analog control outputs, all from flops
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_modulator_run <= 1'b0;
      o_channel_run <= 6'h00;
      o_standby <= 1'b0;
      o_osc_enable <= 1'b0;
      o_phase_cal_off <= 1'b0;
      o_power_mode <= 2'h0;
      o_device_reset <= 1'b0;
    end else begin
      o_modulator_run <= (mode_reg == MD_RUN) && !pin_reset_reg;
      o_channel_run <= (mode_reg == MD_RUN) ? i_channel_enable_bits : 6'h00;
      o_standby <= (mode_reg == MD_STANDBY);
      o_osc_enable <= (mode_reg == MD_DETECT);
      o_phase_cal_off <= i_chop_cfg.chop_enable;
      o_power_mode <= i_power_mode_select;
      o_device_reset <= pin_reset_reg;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_cmd(logic [15:0] code);
    cmd_stb_reg && cmd_reg == code;
  endsequence
  sequence s_low_hold;
    !o_data_ready_n [*8] ##1 o_data_ready_n;
  endsequence

  a_standby_cmd: assert property ((mode_reg == MD_RUN) ##0 s_cmd(`AMSQ_CMD_STANDBY)
    |=> ##1 o_standby && o_channel_run == 6'h00) else $error("standby not entered");
  a_wake_cmd: assert property ((mode_reg == MD_STANDBY) ##0 s_cmd(`AMSQ_CMD_EXIT_STANDBY_COMMAND)
    |=> mode_reg == MD_WAKE) else $error("wake not started");
  a_data_ready_n_pulse: assert property ($fell(o_data_ready_n) && !pin_reset_reg |-> s_low_hold)
    else $error("data-ready pulse length wrong");
  a_swap_filter: assert property ($changed(o_input_swap) |-> o_filter_reset)
    else $error("swap without filter reset");
  a_cd_entry: assert property ($rose(o_osc_enable) |-> $past(mode_reg, 2) == MD_STANDBY)
    else $error("detect entered outside standby");
  a_cd_notify: assert property (cd_tick && detected && !cmd_stb_reg
    |=> mode_reg == MD_STANDBY ##1 !o_data_ready_n) else $error("detect not reported");
  a_dout_float: assert property (cs_hi |=> !o_dout_oe && bit_cnt_reg == 5'h00)
    else $error("output driven while deselected");
  a_osr_restart: assert property (restart && i_chop_cfg.chop_enable && !pin_reset_reg
    |=> gc_reg == GC_START && tick_cnt_reg == 17'h00000) else $error("no restart");
  a_pin_reset: assert property (!sync2_reg[3] && low_cnt_reg >= 16'(RST_CYC)
    |=> ##1 o_device_reset) else $error("long sync low did not reset");
  a_phase_off: assert property (i_chop_cfg.chop_enable |=> o_phase_cal_off)
    else $error("phase calibration left on");
endmodule : amsq_top

// ### testbench.sv
`timescale 1ns/1ns
module testbench import amsq_pkg::*; ;
  logic clk_sys, rst, sclk, cs_n, din, dout, dout_oe, sync_n, conv_clk, conv_on, data_ready_n_n;
  logic [1:0] pwr, pmode;
  logic [5:0] ch_en, ch_run;
  logic signed [23:0] raw, chop_res;
  logic swap, frst, mod_run, standby, osc, pcal_off, dev_rst;
  logic [15:0] rx;
  amsq_chop_cfg_t chop_cfg;
  amsq_cd_cfg_t cd_cfg;
  amsq_cd_samples_t samples;
  int n_fail, compares, n_mod, lows, n_frst;

  // Short detect tick keeps each detect run to a few thousand cycles
  amsq_top #(.CD_TICK_CYC(20)) i_amsq_top (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
    .o_dout(dout), .o_dout_oe(dout_oe), .i_sync_rst_n(sync_n),
    .i_converter_clock_in(conv_clk), .o_data_ready_n(data_ready_n_n), .i_chop_cfg(chop_cfg),
    .i_power_mode_select(pwr), .i_cd_cfg(cd_cfg), .i_channel_enable_bits(ch_en),
    .i_raw_result(raw), .i_cd_samples(samples), .o_chop_result(chop_res),
    .o_input_swap(swap), .o_filter_reset(frst), .o_modulator_run(mod_run),
    .o_channel_run(ch_run), .o_standby(standby), .o_osc_enable(osc),
    .o_phase_cal_off(pcal_off), .o_power_mode(pmode), .o_device_reset(dev_rst));
  amsq_host_model i_amsq_host_model (.o_sclk(sclk), .o_cs_n(cs_n), .o_din(din),
    .i_dout(dout), .i_dout_oe(dout_oe));

  // Clocks; the converter clock stands low while halted
  always #2 clk_sys = ~clk_sys;
  always #20 conv_clk = conv_on ? ~conv_clk : 1'b0;
  always @(posedge conv_clk) n_mod++;
  // Filter reset pulses, counted to tie restarts and swaps to the filter
  always @(posedge clk_sys) if (frst === 1'b1) n_frst++;
  // Results alternate with polarity, so only a two-result average gives 0x200
  always @(posedge clk_sys) raw <= swap ? 24'sh000300 : 24'sh000100;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : rng
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // Bounded wait: sel 0 for data-ready low, sel 1 for modulator running
  task automatic wait_for(input int sel, input int bound);
    int k;
    k = 0;
    while ((sel == 0 ? data_ready_n_n !== 1'b0 : mod_run !== 1'b1) && k < bound) begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= bound) begin
      n_fail++;
      $display("BAD t=%0t wait %h timed out", $time, sel);
      summarize();
    end
  endtask : wait_for
  task automatic summarize();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  initial begin
    clk_sys = 1'b0;
    rst = 1'b1;
    sync_n = 1'b1;
    conv_clk = 1'b0;
    conv_on = 1'b1;
    chop_cfg = '0;
    pwr = 2'h0;
    cd_cfg = '0;
    ch_en = 6'h3f;
    raw = '0;
    samples = '0;
    n_fail = 0;
    compares = 0;
    n_mod = 0;
    tick(2);
    rst <= 1'b0;
    tick(4);
    chk(32'(data_ready_n_n), 32'h1);
    chk(32'(dout_oe), 32'h0);
    chk(32'(standby), 32'h0);
    for (int i = 0; i < 4; i++) begin
      pwr <= 2'(i);
      tick(3);
      chk(32'(pmode), 32'(i));
    end
    $display("test reset and power done");
    // First chopped result after 44 + 2 * (2 + 3 * 128) modulator periods
    chop_cfg <= '{chop_enable: 1'b1, chop_settle_delay: 4'h0, osr_select: 3'h0};
    n_mod = 0;
    n_frst = 0;
    wait_for(0, 9000);
    rng(n_mod, 815, 818);
    chk(32'(chop_res), 32'h200);
    chk(32'(pcal_off), 32'h1);
    // Two swaps since the start leave the polarity normal again
    chk(32'(swap), 32'h0);
    tick(1);
    chk(32'(n_frst), 32'h3);
    n_mod = 0;
    tick(10);
    wait_for(0, 4500);
    rng(n_mod, 385, 388);
    // Changing the ratio restarts; delay code 1 gives 4: 44 + 2 * (4 + 3 * 256)
    chop_cfg.chop_settle_delay <= 4'h1;
    chop_cfg.osr_select <= 3'h1;
    n_mod = 0;
    tick(10);
    wait_for(0, 17000);
    rng(n_mod, 1587, 1590);
    chop_cfg <= '0;
    $display("test chop done");
    i_amsq_host_model.xfer(16'h0022, rx);
    tick(4);
    conv_on = 1'b0;
    chk(32'(standby), 32'h1);
    chk(32'(ch_run), 32'h0);
    chk(32'(pmode), 32'h3);
    i_amsq_host_model.xfer(16'h0000, rx);
    chk(32'(rx), {16'h0, 1'b1, 1'b0, 1'b0, pwr, 11'h000});
    chk(32'(dout_oe), 32'h0);
    $display("test standby done");
    // Channels 0 and 1 must both exceed; channel 2 is over but not enabled
    tick(1);
    ch_en <= 6'h03;
    cd_cfg <= {1'b1, 1'b1, 3'h0, 3'h0, 16'h0001, 8'h00};
    samples[0] <= 24'h000200;
    samples[2] <= 24'h000200;
    tick(2);
    sync_n <= 1'b0;
    tick(20);
    sync_n <= 1'b1;
    tick(10);
    chk(32'(osc), 32'h1);
    lows = 0;
    // Longer than one run of 128 samples, so a fresh run must start quietly
    repeat (3000) begin
      @(posedge clk_sys);
      if (data_ready_n_n !== 1'b1) lows++;
    end
    chk(32'(lows), 32'h0);
    chk(32'(osc), 32'h1);
    samples[1] <= 24'hfffe00;
    wait_for(0, 400);
    tick(12);
    chk(32'(standby), 32'h1);
    chk(32'(osc), 32'h0);
    // Any-channel mode: channel 1 alone must collect three hits first
    cd_cfg.detect_all_channels <= 1'b0;
    cd_cfg.detect_hit_count <= 3'h2;
    samples[0] <= 24'h000000;
    tick(2);
    sync_n <= 1'b0;
    tick(20);
    sync_n <= 1'b1;
    lows = 0;
    repeat (45) begin
      @(posedge clk_sys);
      if (data_ready_n_n !== 1'b1) lows++;
    end
    chk(32'(lows), 32'h0);
    wait_for(0, 60);
    tick(12);
    chk(32'(standby), 32'h1);
    $display("test detect done");
    i_amsq_host_model.xfer(16'h0033, rx);
    n_mod = 0;
    conv_on = 1'b1;
    wait_for(1, 500);
    rng(n_mod, 8, 9);
    // A short pulse outside standby must not enter detect
    tick(1);
    sync_n <= 1'b0;
    tick(20);
    sync_n <= 1'b1;
    tick(10);
    chk(32'(osc), 32'h0);
    sync_n <= 1'b0;
    tick(300);
    chk(32'(dev_rst), 32'h1);
    chk(32'(mod_run), 32'h0);
    sync_n <= 1'b1;
    tick(10);
    chk(32'(dev_rst), 32'h0);
    $display("test wake and pin reset done");
    summarize();
  end
endmodule : testbench
